// file: design/iirq_pkg.sv
package iirq_pkg;

  // ****************************************************************
  // register byte offsets (AXI4-Lite, one word each)
  // ****************************************************************
  localparam logic [7:0] ADDR_IRQ_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_OVERVIEW     = 8'h04;
  localparam logic [7:0] ADDR_LINE_STATUS  = 8'h08;
  localparam logic [7:0] ADDR_LINE_MASK    = 8'h0C;
  localparam logic [7:0] ADDR_FIFO_BLK0    = 8'h10;
  localparam logic [7:0] ADDR_FIFO_BLK1    = 8'h14;
  localparam logic [7:0] ADDR_FIFO_BLK2    = 8'h18;
  localparam logic [7:0] ADDR_FIFO_BLK3    = 8'h1C;
  localparam logic [7:0] ADDR_FIFO_MASK0   = 8'h20;
  localparam logic [7:0] ADDR_FIFO_MASK1   = 8'h24;
  localparam logic [7:0] ADDR_FIFO_MASK2   = 8'h28;
  localparam logic [7:0] ADDR_FIFO_MASK3   = 8'h2C;
  localparam logic [7:0] ADDR_MISC_STATUS  = 8'h30;
  localparam logic [7:0] ADDR_MISC_MASK    = 8'h34;
  localparam logic [7:0] ADDR_TIMER_SCALE  = 8'h38;
  localparam logic [7:0] ADDR_PIN_MODE     = 8'h3C;
  localparam logic [7:0] ADDR_FIFO_CFG_LO  = 8'h40;
  localparam logic [7:0] ADDR_FIFO_CFG_HI  = 8'hBC;

  // ****************************************************************
  // fields
  // ****************************************************************
  localparam int CTRL_FIFO_EN_BIT   = 0;
  localparam int CTRL_GLOBAL_EN_BIT = 3;
  localparam int CTRL_POLARITY_BIT  = 4;
  localparam int OVW_MISC_BIT       = 4;
  localparam int OVW_LINE_BIT       = 5;
  localparam int MISC_SLIP_BIT      = 0;
  localparam int MISC_TIMER_BIT     = 1;
  localparam int MISC_PROC_BIT      = 2;
  localparam int MISC_CI_BIT        = 3;
  localparam int MISC_WAKE_BIT      = 4;
  localparam int MISC_MON_TX_BIT    = 5;
  localparam int MISC_MON_RX_BIT    = 6;
  localparam int CFG_TRANSP_BIT     = 0;
  localparam int CFG_MIX_BIT        = 1;
  localparam int CFG_COND_LSB       = 2;
  localparam int PIN_WAKE_EN_BIT    = 0;

  localparam int NUM_FIFOS  = 32;
  localparam int NUM_BLOCKS = 4;
  localparam int MISC_W     = 7;
  localparam int CI_W       = 4;
  localparam int COND_W     = 3;
  localparam int TSCALE_W   = 4;

  // reset values: all sources disabled
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // ****************************************************************
  // timing: frame pulse every 125 us, timer base 250 us
  // ****************************************************************
  localparam int TIMER_BASE_US  = 250;
  localparam int FRAME_US       = 125;
  localparam int TIMER_BASE_FRM = TIMER_BASE_US / FRAME_US;
  localparam int TCNT_W         = 17;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : iirq_pkg

// file: design/iirq_engine.sv
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none

module iirq_engine
  import iirq_pkg::*;
(
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  // axi4-lite slave
  input  wire logic [7:0]           i_awaddr,
  input  wire logic                 i_awvalid,
  output logic                      o_awready,
  input  wire logic [31:0]          i_wdata,
  input  wire logic [3:0]           i_wstrb,
  input  wire logic                 i_wvalid,
  output logic                      o_wready,
  output logic [1:0]                o_bresp,
  output logic                      o_bvalid,
  input  wire logic                 i_bready,
  input  wire logic [7:0]           i_araddr,
  input  wire logic                 i_arvalid,
  output logic                      o_arready,
  output logic [31:0]               o_rdata,
  output logic [1:0]                o_rresp,
  output logic                      o_rvalid,
  input  wire logic                 i_rready,
  // event sources
  input  wire logic                 i_line_state_change,
  input  wire logic [NUM_FIFOS-1:0] i_fifo_end_of_frame,
  input  wire logic [NUM_FIFOS-1:0] i_fifo_underrun,
  input  wire logic [NUM_FIFOS-1:0] i_fifo_cond_met,
  input  wire logic                 i_frame_sync_source_sel,
  input  wire logic                 i_frame_pulse_primary,
  input  wire logic                 i_proc_active,
  input  wire logic [CI_W-1:0]      i_ci_indication,
  input  wire logic                 i_wake_pin,
  input  wire logic                 i_monitor_tx_ready,
  input  wire logic                 i_monitor_rx_stored,
  // per-fifo condition select for the source logic
  output logic [NUM_FIFOS*COND_W-1:0] o_fifo_cond_sel,
  // interrupt pin, open drain when active low
  output logic                      o_irq,
  output logic                      o_irq_oe
);

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0]           irq_ctrl;
  logic [7:0]           line_irq_status_reg;
  logic [7:0]           line_irq_mask_reg;
  logic [NUM_FIFOS-1:0] fifo_status;
  logic [NUM_FIFOS-1:0] fifo_mask;
  logic [MISC_W-1:0]    misc_status;
  logic [MISC_W-1:0]    misc_mask_reg;
  logic [TSCALE_W-1:0]  timer_event_scale;
  logic                 wake_pin_enable;
  logic [7:0]           fifo_config_reg [NUM_FIFOS];

  // ****************************************************************
  // bus handshake
  // ****************************************************************
  logic aw_held;
  logic w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  // aw and w are taken in either order; the early one is parked until its partner arrives
  // nothing new is taken while a response waits, so one write at most is in flight
  assign o_awready = ~aw_held & ~o_bvalid;
  assign o_wready  = ~w_held & ~o_bvalid;
  assign o_arready = ~o_rvalid;

  wire aw_fire = i_awvalid & o_awready;
  wire w_fire  = i_wvalid & o_wready;
  wire ar_fire = i_arvalid & o_arready;

  wire       have_aw  = aw_held | aw_fire;
  wire       have_w   = w_held | w_fire;
  wire       wr_go    = have_aw & have_w;
  wire [7:0] wr_addr  = aw_held ? aw_addr : i_awaddr;
  wire [31:0] wr_data = w_held ? w_data : i_wdata;
  wire [3:0] wr_strb  = w_held ? w_strb : i_wstrb;
  wire       wr_lane0 = wr_go & wr_strb[0];

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      aw_held <= have_aw & ~wr_go;
      w_held  <= have_w & ~wr_go;
      if (aw_fire) aw_addr <= i_awaddr;
      if (w_fire) begin
        w_data <= i_wdata;
        w_strb <= i_wstrb;
      end
    end
  end

  // ****************************************************************
  // address decode
  // ****************************************************************
  wire wr_ctrl    = wr_lane0 & (wr_addr == ADDR_IRQ_CTRL);
  wire wr_lmask   = wr_lane0 & (wr_addr == ADDR_LINE_MASK);
  wire wr_mmask   = wr_lane0 & (wr_addr == ADDR_MISC_MASK);
  wire wr_tscale  = wr_lane0 & (wr_addr == ADDR_TIMER_SCALE);
  wire wr_pmode   = wr_lane0 & (wr_addr == ADDR_PIN_MODE);
  wire wr_fmask   = wr_lane0 & (wr_addr[7:4] == ADDR_FIFO_MASK0[7:4]);
  wire wr_cfg     = wr_lane0 & (wr_addr >= ADDR_FIFO_CFG_LO) & (wr_addr <= ADDR_FIFO_CFG_HI);
  wire [4:0] cfg_wr_idx = 5'(wr_addr[7:2] - ADDR_FIFO_CFG_LO[7:2]);
  wire [1:0] fmask_blk  = wr_addr[3:2];

  // status and overview take writes and drop them; only unknown offsets are refused
  // a write without byte lane 0 changes nothing and still answers okay
  wire wr_mapped = wr_ctrl | wr_lmask | wr_mmask | wr_tscale | wr_pmode | wr_fmask | wr_cfg
                 | (wr_addr == ADDR_OVERVIEW) | (wr_addr == ADDR_LINE_STATUS)
                 | (wr_addr == ADDR_MISC_STATUS) | (wr_addr[7:4] == ADDR_FIFO_BLK0[7:4])
                 | ~wr_strb[0];

  // read decode runs straight off the bus address; data is captured at the ar handshake
  wire [7:0] rd_addr = i_araddr;
  wire rd_line  = ar_fire & (rd_addr == ADDR_LINE_STATUS);
  wire rd_misc  = ar_fire & (rd_addr == ADDR_MISC_STATUS);
  wire rd_fblk  = ar_fire & (rd_addr[7:4] == ADDR_FIFO_BLK0[7:4]);
  wire [1:0] rd_blk = rd_addr[3:2];
  wire [4:0] cfg_rd_idx = 5'(rd_addr[7:2] - ADDR_FIFO_CFG_LO[7:2]);
  wire rd_cfg_hit = (rd_addr >= ADDR_FIFO_CFG_LO) & (rd_addr <= ADDR_FIFO_CFG_HI);

  // ****************************************************************
  // event generation
  // ****************************************************************
  logic                sync_sel_q;
  logic                proc_q;
  logic [CI_W-1:0]     ci_q;
  logic                mon_tx_q;
  logic                mon_rx_q;
  logic [TCNT_W-1:0]   timer_cnt;
  logic                track_valid;

  // 17 bits hold the longest period, 2^15 * 2 frame pulses
  // writing the scale restarts the count so the first period after a change is whole
  // period in frame pulses is 2^N * 2
  wire [TCNT_W-1:0] timer_period = TCNT_W'(TIMER_BASE_FRM) << timer_event_scale;
  wire timer_hit = i_frame_pulse_primary & (timer_cnt == timer_period - 1'b1);

  // events; slip and ci changes are suppressed on the first cycle after reset so no spurious change fires
  wire ev_slip   = track_valid & (i_frame_sync_source_sel != sync_sel_q);
  wire ev_proc   = proc_q & ~i_proc_active;
  wire ev_ci     = track_valid & (i_ci_indication != ci_q);
  wire ev_wake   = wake_pin_enable & i_wake_pin;
  // monitor lines are levels; only their rising edge counts as an event
  wire ev_mon_tx = i_monitor_tx_ready & ~mon_tx_q;
  wire ev_mon_rx = i_monitor_rx_stored & ~mon_rx_q;

  wire [MISC_W-1:0] misc_events;
  assign misc_events[MISC_SLIP_BIT]   = ev_slip;
  assign misc_events[MISC_TIMER_BIT]  = timer_hit;
  assign misc_events[MISC_PROC_BIT]   = ev_proc;
  assign misc_events[MISC_CI_BIT]     = ev_ci;
  assign misc_events[MISC_WAKE_BIT]   = ev_wake;
  assign misc_events[MISC_MON_TX_BIT] = ev_mon_tx;
  assign misc_events[MISC_MON_RX_BIT] = ev_mon_rx;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sync_sel_q  <= 1'b0;
      proc_q      <= 1'b0;
      ci_q        <= '0;
      mon_tx_q    <= 1'b0;
      mon_rx_q    <= 1'b0;
      track_valid <= 1'b0;
      timer_cnt   <= '0;
    end else begin
      sync_sel_q  <= i_frame_sync_source_sel;
      proc_q      <= i_proc_active;
      ci_q        <= i_ci_indication;
      mon_tx_q    <= i_monitor_tx_ready;
      mon_rx_q    <= i_monitor_rx_stored;
      track_valid <= 1'b1;
      // a scale write wins over a pending hit
      if (wr_tscale) timer_cnt <= '0;
      else if (timer_hit) timer_cnt <= '0;
      else if (i_frame_pulse_primary) timer_cnt <= timer_cnt + 1'b1;
    end
  end

  // ****************************************************************
  // fifo event selection per mode
  // ****************************************************************
  // the programmed condition is judged in the fifo logic; only its select leaves here
  logic [NUM_FIFOS-1:0] fifo_events;
  always_comb begin
    for (int f = 0; f < NUM_FIFOS; f++) begin
      if (fifo_config_reg[f][CFG_TRANSP_BIT]) begin
        fifo_events[f] = i_fifo_cond_met[f];
      end else if (fifo_config_reg[f][CFG_MIX_BIT]) begin
        fifo_events[f] = i_fifo_end_of_frame[f] | i_fifo_underrun[f]
                       | i_fifo_cond_met[f];
      end else begin
        fifo_events[f] = i_fifo_end_of_frame[f] | i_fifo_underrun[f];
      end
      o_fifo_cond_sel[f*COND_W +: COND_W] = fifo_config_reg[f][CFG_COND_LSB +: COND_W];
    end
  end

  // the enable gates the set only; bits already pending stay until read
  wire [NUM_FIFOS-1:0] fifo_set = fifo_events & {NUM_FIFOS{irq_ctrl[CTRL_FIFO_EN_BIT]}};

  // ****************************************************************
  // clear-on-read masks, set wins over clear
  // ****************************************************************
  // the clear takes the address of the read accepted this cycle, so data and clear agree
  // an event in that same cycle is or-ed in afterwards and waits for the next read
  wire [NUM_FIFOS-1:0] fifo_clr = rd_fblk ? (NUM_FIFOS'(32'h0000_00FF) << {rd_blk, 3'b000})
                                          : '0;
  wire [NUM_FIFOS-1:0] next_fifo_status = (fifo_status & ~fifo_clr) | fifo_set;
  wire [MISC_W-1:0] next_misc_status = (misc_status & ~{MISC_W{rd_misc}})
                                     | misc_events;
  wire line_set = i_line_state_change;
  wire [7:0] next_line_status = (line_irq_status_reg & ~{8{rd_line}}) | {7'b0, line_set};

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      fifo_status         <= '0;
      misc_status         <= '0;
      line_irq_status_reg <= RST_BYTE;
    end else begin
      fifo_status         <= next_fifo_status;
      misc_status         <= next_misc_status;
      line_irq_status_reg <= next_line_status;
    end
  end

  // ****************************************************************
  // control registers
  // ****************************************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_ctrl          <= RST_BYTE;
      line_irq_mask_reg <= RST_BYTE;
      misc_mask_reg     <= '0;
      fifo_mask         <= '0;
      timer_event_scale <= '0;
      wake_pin_enable   <= 1'b0;
      for (int f = 0; f < NUM_FIFOS; f++) fifo_config_reg[f] <= RST_BYTE;
    end else begin
      // only the low byte carries register bits
      if (wr_ctrl) irq_ctrl <= wr_data[7:0];
      if (wr_lmask) line_irq_mask_reg <= wr_data[7:0];
      if (wr_mmask) misc_mask_reg <= wr_data[MISC_W-1:0];
      if (wr_fmask) fifo_mask[{fmask_blk, 3'b000} +: 8] <= wr_data[7:0];
      if (wr_tscale) timer_event_scale <= wr_data[TSCALE_W-1:0];
      if (wr_pmode) wake_pin_enable <= wr_data[PIN_WAKE_EN_BIT];
      if (wr_cfg) fifo_config_reg[cfg_wr_idx] <= wr_data[7:0];
    end
  end

  // ****************************************************************
  // overview and pin
  // ****************************************************************
  // summaries follow the status directly and clear with it
  wire [NUM_BLOCKS-1:0] blk_summary;
  for (genvar b = 0; b < NUM_BLOCKS; b++) begin : g_blk
    assign blk_summary[b] = |fifo_status[b*8 +: 8];
  end
  wire misc_summary = |misc_status;
  wire line_summary = |line_irq_status_reg;
  // the line summary shares the overview so one read shows where to look
  wire [7:0] overview = {2'b00, line_summary, misc_summary, blk_summary};

  // masks act only on the pin; status bits are recorded regardless
  wire pending = |(fifo_status & fifo_mask) | |(misc_status & misc_mask_reg)
               | |(line_irq_status_reg & line_irq_mask_reg);
  wire irq_active = irq_ctrl[CTRL_GLOBAL_EN_BIT] & pending;

  // active low drives only low (open drain, shareable); active high drives both levels
  // registered pin: one cycle behind the status, but never glitches towards the host
  // limitation: active high drives the line at all times, so it cannot be shared
  logic irq_pin;
  logic irq_pin_oe;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_pin    <= 1'b1;
      irq_pin_oe <= 1'b0;
    end else begin
      irq_pin    <= irq_ctrl[CTRL_POLARITY_BIT] ? irq_active : ~irq_active;
      irq_pin_oe <= irq_ctrl[CTRL_POLARITY_BIT] | irq_active;
    end
  end
  assign o_irq    = irq_pin;
  assign o_irq_oe = irq_pin_oe;

  // ****************************************************************
  // read data and responses
  // ****************************************************************
  // unmapped offsets read as zero and answer slverr
  logic [31:0] rd_word;
  logic        rd_ok;
  always_comb begin
    rd_ok   = 1'b1;
    rd_word = RST_WORD;
    if (rd_cfg_hit) rd_word = {24'h0, fifo_config_reg[cfg_rd_idx]};
    else if (rd_addr[7:4] == ADDR_FIFO_BLK0[7:4])
      rd_word = {24'h0, fifo_status[{rd_blk, 3'b000} +: 8]};
    else if (rd_addr[7:4] == ADDR_FIFO_MASK0[7:4])
      rd_word = {24'h0, fifo_mask[{rd_blk, 3'b000} +: 8]};
    else begin
      unique case (rd_addr)
        ADDR_IRQ_CTRL:    rd_word = {24'h0, irq_ctrl};
        ADDR_OVERVIEW:    rd_word = {24'h0, overview};
        ADDR_LINE_STATUS: rd_word = {24'h0, line_irq_status_reg};
        ADDR_LINE_MASK:   rd_word = {24'h0, line_irq_mask_reg};
        ADDR_MISC_STATUS: rd_word = {25'h0, misc_status};
        ADDR_MISC_MASK:   rd_word = {25'h0, misc_mask_reg};
        ADDR_TIMER_SCALE: rd_word = {28'h0, timer_event_scale};
        ADDR_PIN_MODE:    rd_word = {31'h0, wake_pin_enable};
        default:          rd_ok   = 1'b0;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_bvalid <= 1'b0;
      o_bresp  <= RESP_OKAY;
      o_rvalid <= 1'b0;
      o_rresp  <= RESP_OKAY;
      o_rdata  <= RST_WORD;
    end else begin
      if (wr_go) begin
        o_bvalid <= 1'b1;
        o_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (i_bready) o_bvalid <= 1'b0;
      // read data is taken before this edge's clear reaches the status
      if (ar_fire) begin
        o_rvalid <= 1'b1;
        o_rdata  <= rd_word;
        o_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (i_rready) o_rvalid <= 1'b0;
    end
  end

endmodule : iirq_engine

`default_nettype wire

// file: dv/iirq_irq_line.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// host side of the interrupt line
// ****************************************************************
module iirq_irq_line (
  input  wire logic i_irq,
  input  wire logic i_irq_oe,
  output logic      o_line
);
  // pull-up: a released open-drain line reads high
  assign o_line = i_irq_oe ? i_irq : 1'b1;
endmodule : iirq_irq_line

`default_nettype wire

// file: dv/iirq_checker.sv
`timescale 1ns/10ps
`default_nettype none

module iirq_checker
  import iirq_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_awvalid,
  input  wire logic        o_awready,
  input  wire logic        i_wvalid,
  input  wire logic        o_wready,
  input  wire logic        o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  input  wire logic        o_arready,
  input  wire logic        o_rvalid,
  input  wire logic [31:0] o_rdata,
  input  wire logic [1:0]  o_rresp,
  input  wire logic        i_rready,
  input  wire logic        o_irq,
  input  wire logic        o_irq_oe
);
  // ****************************************************************
  // helpers
  // ****************************************************************
  logic      wrote;
  wire logic ar_take = i_arvalid && o_arready;
  wire logic aw_take = i_awvalid && o_awready && i_wvalid && o_wready;

  // nothing can enable the pin before software's first write
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst)
      wrote <= 1'b0;
    else if (i_awvalid && o_awready)
      wrote <= 1'b1;
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // ****************************************************************
  // properties
  // ****************************************************************
  AST_IRQ_RELEASED_HIGH: assert property (!o_irq_oe |-> o_irq)
    else $error("released interrupt pin not high");
  AST_QUIET_AFTER_RESET: assert property (!wrote |-> !o_irq_oe)
    else $error("interrupt pin driven before any write");
  AST_B_AFTER_WRITE: assert property (aw_take |=> o_bvalid)
    else $error("write response late");
  AST_R_AFTER_READ: assert property (ar_take |=> o_rvalid)
    else $error("read response late");
  AST_R_DROP: assert property (o_rvalid && i_rready |=> !o_rvalid)
    else $error("read response not released");
  AST_B_DROP: assert property (o_bvalid && i_bready |=> !o_bvalid)
    else $error("write response not released");
  AST_AR_BLOCKED: assert property (o_rvalid |-> !o_arready)
    else $error("read address taken while response pending");
  AST_BAD_READ: assert property (ar_take && i_araddr > 8'hBC
      |=> o_rresp == RESP_SLVERR && o_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");

  COV_BAD_READ: cover property (ar_take && i_araddr > 8'hBC);
  COV_IRQ_LOW: cover property (o_irq_oe && !o_irq);
  COV_IRQ_HIGH: cover property (o_irq_oe && o_irq);
endmodule : iirq_checker

bind iirq_engine iirq_checker iirq_checker_inst (.*);

`default_nettype wire

// file: dv/iirq_engine_tb.sv
`timescale 1ns/10ps
`default_nettype none

module iirq_engine_tb import iirq_pkg::*; ;
  logic i_clk, i_rst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic i_line_state_change, i_frame_sync_source_sel, i_frame_pulse_primary;
  logic i_proc_active, i_wake_pin, i_monitor_tx_ready, i_monitor_rx_stored;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq, o_irq_oe;
  logic [7:0]  i_awaddr, i_araddr, ba, ca;
  logic [31:0] i_wdata, o_rdata, rd, v;
  logic [3:0]  i_wstrb, i_ci_indication;
  logic [1:0]  o_bresp, o_rresp, rs;
  logic [NUM_FIFOS-1:0] i_fifo_end_of_frame, i_fifo_underrun, i_fifo_cond_met;
  logic [NUM_FIFOS*COND_W-1:0] o_fifo_cond_sel;
  logic [31:0] seed = 32'h0000_0b0c;
  int          miscompares = 0;
  int          tests_run = 0;
  int          f, k;
  int          fs[5] = '{0, 1, 2, 2, 2};
  int          fe[5] = '{1, 1, 0, 1, 1};
  logic [1:0]  cm[5] = '{2'b00, 2'b00, 2'b00, 2'b10, 2'b01};
  logic [7:0]  rz[7] = '{8'h00, 8'h0C, 8'h20, 8'h34, 8'h38, 8'h3C, 8'h40};
  wire logic   irq_line;

  iirq_engine iirq_engine_inst (.*);
  iirq_irq_line iirq_irq_line_inst (.i_irq(o_irq), .i_irq_oe(o_irq_oe), .o_line(irq_line));

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ta, tw;
    @(posedge i_clk);
    {i_awaddr, i_wdata, i_awvalid, i_wvalid, i_bready} <= {a, d, 3'b111};
    {ta, tw, rs} = 4'b0011;
    forever begin
      @(posedge i_clk);
      if (o_bvalid && ta && tw) begin
        rs = o_bresp;
        i_bready <= 1'b0;
        break;
      end
      if (o_awready && !ta) begin
        ta = 1'b1;
        i_awvalid <= 1'b0;
      end
      if (o_wready && !tw) begin
        tw = 1'b1;
        i_wvalid <= 1'b0;
      end
    end
  endtask : wr

  // sx raises the monitor receive line in the same cycle as the read
  task automatic rdr(input logic [7:0] a, input bit sx);
    bit ta;
    @(posedge i_clk);
    {i_araddr, i_arvalid, i_rready, i_monitor_rx_stored} <= {a, 2'b11, sx};
    {ta, rs, rd} = {3'b011, 32'h0000_0000};
    forever begin
      @(posedge i_clk);
      if (o_rvalid && ta) begin
        {rs, rd} = {o_rresp, o_rdata};
        i_rready <= 1'b0;
        break;
      end
      if (o_arready && !ta) begin
        ta = 1'b1;
        i_arvalid <= 1'b0;
      end
    end
  endtask : rdr

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rdr(a, 1'b0);
    chk({rs, rd}, {RESP_OKAY, e});
  endtask : rchk

  task automatic wchk(input logic [7:0] a, input logic [31:0] d);
    wr(a, d);
    chk(rs, RESP_OKAY);
  endtask : wchk

  task automatic ev(input int s);
    @(posedge i_clk);
    v = rnd();
    case (s)
      0: i_frame_sync_source_sel <= ~i_frame_sync_source_sel;
      1: i_frame_pulse_primary <= 1'b1;
      2: i_proc_active <= 1'b1;
      3: i_ci_indication <= i_ci_indication ^ (v[3:0] | 4'h1);
      4: i_wake_pin <= 1'b1;
      5: i_monitor_tx_ready <= 1'b1;
      default: i_monitor_rx_stored <= 1'b1;
    endcase
    @(posedge i_clk);
    {i_frame_pulse_primary, i_proc_active, i_wake_pin, i_monitor_tx_ready,
     i_monitor_rx_stored, i_line_state_change, i_fifo_end_of_frame,
     i_fifo_underrun, i_fifo_cond_met} <= '0;
    repeat (3) @(posedge i_clk);
  endtask : ev

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  initial begin
    repeat (20000) @(posedge i_clk);
    miscompares++;
    conclude();
  end

  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    {i_awaddr, i_araddr, i_wdata, i_ci_indication} = '0;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_line_state_change,
     i_frame_sync_source_sel, i_frame_pulse_primary, i_proc_active, i_wake_pin,
     i_monitor_tx_ready, i_monitor_rx_stored, i_fifo_end_of_frame,
     i_fifo_underrun, i_fifo_cond_met} = '0;
    i_wstrb = 4'hF;
    i_rst = 1'b1;
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    foreach (rz[i]) rchk(rz[i], 32'h0000_0000);
    chk(irq_line, 1'b1);
    rdr(8'hC0, 1'b0);
    chk({rs, rd}, {RESP_SLVERR, 32'h0000_0000});
    wr(8'hC4, 32'h0000_00FF);
    chk(rs, RESP_SLVERR);
    wchk(ADDR_IRQ_CTRL, 32'h0000_0008);
    wchk(ADDR_PIN_MODE, 32'h0000_0001);
    wchk(ADDR_TIMER_SCALE, 32'h0000_0001);
    // masks all clear, so the pin must stay released with global enable on
    for (k = 0; k < MISC_W; k++) begin
      if (k == 1) begin
        repeat (3) ev(1);
        rchk(ADDR_MISC_STATUS, 32'h0000_0000);
      end
      ev(k);
      chk(irq_line, 1'b1);
      rchk(ADDR_MISC_STATUS, 32'h1 << k);
      rchk(ADDR_MISC_STATUS, 32'h0000_0000);
    end
    rdr(ADDR_MISC_STATUS, 1'b1);
    chk({rs, rd}, {RESP_OKAY, 32'h0000_0000});
    rchk(ADDR_MISC_STATUS, 32'h0000_0040);
    @(posedge i_clk);
    i_line_state_change <= 1'b1;
    ev(2);
    rchk(ADDR_MISC_STATUS, 32'h0000_0004);
    rchk(ADDR_OVERVIEW, 32'h0000_0020);
    rchk(ADDR_LINE_STATUS, 32'h0000_0001);
    rchk(ADDR_LINE_STATUS, 32'h0000_0000);
    v = rnd();
    f = int'(v[4:0]);
    ba = 8'(ADDR_FIFO_BLK0 + 4 * (f / 8));
    ca = 8'(ADDR_FIFO_CFG_LO + 4 * f);
    @(posedge i_clk);
    i_fifo_end_of_frame[f] <= 1'b1;
    ev(2);
    rchk(ba, 32'h0000_0000);
    wchk(ADDR_IRQ_CTRL, 32'h0000_0009);
    for (k = 0; k < 5; k++) begin
      v = rnd();
      wchk(ca, {27'h0, v[2:0], cm[k]});
      chk(o_fifo_cond_sel[f*COND_W +: COND_W], v[2:0]);
      @(posedge i_clk);
      i_fifo_end_of_frame[f] <= (fs[k] == 0);
      i_fifo_underrun[f] <= (fs[k] == 1);
      i_fifo_cond_met[f] <= (fs[k] == 2);
      ev(2);
      rchk(ADDR_MISC_STATUS, 32'h0000_0004);
      if (k == 0) rchk(ADDR_OVERVIEW, 32'h1 << (f / 8));
      rchk(ba, fe[k] << (f % 8));
    end
    wchk(ADDR_MISC_MASK, 32'h0000_0010);
    wchk(ADDR_IRQ_CTRL, 32'h0000_0000);
    ev(4);
    chk(irq_line, 1'b1);
    wchk(ADDR_IRQ_CTRL, 32'h0000_0008);
    repeat (3) @(posedge i_clk);
    chk(irq_line, 1'b0);
    rchk(ADDR_MISC_STATUS, 32'h0000_0010);
    repeat (3) @(posedge i_clk);
    chk(irq_line, 1'b1);
    wchk(ADDR_IRQ_CTRL, 32'h0000_0018);
    ev(4);
    chk({o_irq, o_irq_oe}, 2'b11);
    wchk(ADDR_MISC_MASK, 32'h0000_0000);
    repeat (3) @(posedge i_clk);
    chk({o_irq, o_irq_oe}, 2'b01);
    // lane 0 off writes nothing; then line and fifo masks drive the pin
    i_wstrb <= 4'hE;
    wchk(ADDR_LINE_MASK, 32'h0000_0001);
    i_wstrb <= 4'hF;
    rchk(ADDR_LINE_MASK, 32'h0000_0000);
    wchk(ADDR_LINE_MASK, 32'h0000_0001);
    @(posedge i_clk);
    i_line_state_change <= 1'b1;
    ev(2);
    chk({o_irq, o_irq_oe}, 2'b11);
    rchk(ADDR_LINE_STATUS, 32'h0000_0001);
    repeat (3) @(posedge i_clk);
    chk({o_irq, o_irq_oe}, 2'b01);
    wchk(ADDR_IRQ_CTRL, 32'h0000_0019);
    wchk(ba, 32'h0000_00FF);
    rchk(ba, 32'h0000_0000);
    wchk(8'(ADDR_FIFO_MASK0 + 4 * (f / 8)), 32'h1 << (f % 8));
    @(posedge i_clk);
    i_fifo_cond_met[f] <= 1'b1;
    ev(2);
    chk({o_irq, o_irq_oe}, 2'b11);
    rchk(ba, 32'h1 << (f % 8));
    conclude();
  end
endmodule : iirq_engine_tb

`default_nettype wire
